// File: include/pmrm_consts.svh
// Constants for the receive MII and management pin block.
`ifndef PMRM_CONSTS_SVH
`define PMRM_CONSTS_SVH
`define PMRM_PORTS 6
`define PMRM_NIB_W 4
`define PMRM_SFD_NIB 4'hD
`define PMRM_BAD_SFD_NIB 4'h2
`define PMRM_RXCLK_100_KHZ 25000
`define PMRM_RXCLK_10_KHZ 2500
`define PMRM_MDC_MAX_KHZ 8000
`define PMRM_SYS_KHZ 20000
`endif

// File: include/pmrm_pkg.sv
// Types shared by the receive MII and management pin block.
`default_nettype none
package pmrm_pkg;
  typedef struct packed {
    logic [3:0] nib;
    logic sym4;
    logic data;
    logic bad;
  } pmrm_rxw_type;
  typedef enum logic [1:0] {
    PMRM_IDLE = 2'h0,
    PMRM_PRE = 2'h1,
    PMRM_FRM = 2'h3
  } pmrm_st_type;
endpackage : pmrm_pkg
`default_nettype wire

// File: logic/pmrm_top.sv
// Receive MII for six ports plus management data and interrupt pins.
// Overview of operation
// - Receive-valid is driven from each port's receive clock while code groups map to data.
// - At 10 Mbps receive-valid rises with the second delimiter nibble, D, and holds to packet end.
// - Receive-error is high for an invalid code group or an unlocked recovery PLL.
// - At 10 Mbps receive-error flags a delimiter arriving as A2 instead of 5D.
// - In symbol mode receive-error carries the fifth receive data bit.
// - Each port has a continuous recovered clock timing its data, valid and error.
// - One shared bidirectional management data line, timed by the system clock; the management clock is only sampled.
// - With interrupt enable set, the open-drain interrupt pulls low on status change.
// - Reading register 19 over the management channel clears a pending interrupt.
// - Received data leaves as four-bit nibbles synchronous to the port's receive clock.
`include "pmrm_consts.svh"
`default_nettype none
module pmrm_top (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic speed_100_i,
  input wire logic symbol_mode_i,
  input wire logic [5:0] pll_locked_i,
  input wire logic [5:0] rx_rclk_i,
  input wire pmrm_pkg::pmrm_rxw_type [5:0] rx_word_i,
  input wire logic [5:0] rx_valid_i,
  output logic [5:0] rx_ready_o,
  output logic [5:0] rx_clk_o,
  output logic [5:0] rx_dv_o,
  output logic [5:0] rx_er_o,
  output logic [5:0][3:0] rxd_o,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  output logic mdc_sync_o,
  output logic mdio_sync_o,
  input wire logic mdio_drive_i,
  input wire logic mdio_bit_i,
  input wire logic int_enable_i,
  input wire logic status_change_i,
  input wire logic reg19_read_i,
  output logic mgmt_status_irq_n_o,
  output logic mgmt_status_irq_n_oe_o
);

  function automatic logic [1:0] gray2(input logic [1:0] b);
    gray2 = b ^ {1'b0, b[1]};
  endfunction : gray2

  //////////////////////////////////////////////////////////////////////////////
  // Management pins, sampled into the system clock.

  logic [1:0] mg_s1_q;
  logic [1:0] mg_s2_q;
  logic mdo_q;
  logic mdo_d;
  logic mdoe_q;
  logic mdoe_d;
  logic pend_q;
  logic pend_d;
  logic irq_oe_q;
  logic irq_oe_d;

  // A new status change in the clearing cycle wins, so no event is lost.
  always_comb begin
    mdo_d = mdio_bit_i;
    mdoe_d = mdio_drive_i;
    pend_d = status_change_i | (pend_q & ~reg19_read_i);
    irq_oe_d = pend_d & int_enable_i;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mg_s1_q <= 2'h0;
      mg_s2_q <= 2'h0;
      mdo_q <= 1'b0;
      mdoe_q <= 1'b0;
      pend_q <= 1'b0;
      irq_oe_q <= 1'b0;
    end else begin
      mg_s1_q <= {mdc_i, mdio_i};
      mg_s2_q <= mg_s1_q;
      mdo_q <= mdo_d;
      mdoe_q <= mdoe_d;
      pend_q <= pend_d;
      irq_oe_q <= irq_oe_d;
    end
  end

  assign mdc_sync_o = mg_s2_q[1];
  assign mdio_sync_o = mg_s2_q[0];
  assign mdio_o = mdo_q;
  assign mdio_oe_o = mdoe_q;
  assign mgmt_status_irq_n_o = 1'b0;
  assign mgmt_status_irq_n_oe_o = irq_oe_q;

  property p_irq_set;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    status_change_i && int_enable_i |=> mgmt_status_irq_n_oe_o;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("Interrupt not raised.");

  property p_irq_clr;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    reg19_read_i && !status_change_i |=> !mgmt_status_irq_n_oe_o ##1
      (!mgmt_status_irq_n_oe_o || $past(status_change_i));
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("Interrupt not cleared.");

  property p_irq_both;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    status_change_i && reg19_read_i && int_enable_i |=> mgmt_status_irq_n_oe_o;
  endproperty
  a_irq_both: assert property (p_irq_both) else $error("Clear beat new event.");

  property p_mdio;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    mdio_drive_i |=> mdio_oe_o && (mdio_o == $past(mdio_bit_i));
  endproperty
  a_mdio: assert property (p_mdio) else $error("Data line drive wrong.");

  //////////////////////////////////////////////////////////////////////////////
  // Per-port two-entry buffer crossing into the recovered receive clock.

  assign rx_clk_o = rx_rclk_i;

  for (genvar p = 0; p < `PMRM_PORTS; p++) begin : g_port
    pmrm_pkg::pmrm_rxw_type mem_q [2];
    pmrm_pkg::pmrm_rxw_type mem_d [2];
    pmrm_pkg::pmrm_rxw_type w;
    logic [1:0] wb_q;
    logic [1:0] wb_d;
    logic [1:0] rgs1_q;
    logic [1:0] rgs2_q;
    logic [1:0] rb_q;
    logic [1:0] rb_d;
    logic [1:0] wgs1_q;
    logic [1:0] wgs2_q;
    logic [1:0] wgray_q;
    logic [1:0] rgray_q;
    logic [2:0] cs1_q;
    logic [2:0] cs2_q;
    pmrm_pkg::pmrm_st_type st_q;
    pmrm_pkg::pmrm_st_type st_d;
    logic dv_q;
    logic dv_d;
    logic er_q;
    logic er_d;
    logic [3:0] rxd_q;
    logic [3:0] rxd_d;
    logic full;
    logic emp;
    logic in_pre;

    // The far pointer is compared only after its second sync flop.
    always_comb begin
      full = gray2(wb_q) == ~rgs2_q;
      mem_d = mem_q;
      wb_d = wb_q;
      if (rx_valid_i[p] && !full) begin
        mem_d[wb_q[0]] = rx_word_i[p];
        wb_d = wb_q + 2'h1;
      end
    end

    assign rx_ready_o[p] = ~full;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
        mem_q <= '{default: '0};
        wb_q <= 2'h0;
        rgs1_q <= 2'h0;
        rgs2_q <= 2'h0;
        wgray_q <= 2'h0;
      end else begin
        mem_q <= mem_d;
        wb_q <= wb_d;
        wgray_q <= gray2(wb_d);
        rgs1_q <= rgray_q;
        rgs2_q <= rgs1_q;
      end
    end

    // An empty buffer reads as an idle nibble, which ends any frame in flight.
    always_comb begin
      emp = gray2(rb_q) == wgs2_q;
      w = emp ? '0 : mem_q[rb_q[0]];
      rb_d = emp ? rb_q : rb_q + 2'h1;
      in_pre = st_q != pmrm_pkg::PMRM_FRM;
      st_d = w.data ? pmrm_pkg::PMRM_FRM : pmrm_pkg::PMRM_IDLE;
      dv_d = w.data;
      er_d = w.bad | ~cs2_q[2];
      if (!cs2_q[0]) begin
        case (st_q)
          pmrm_pkg::PMRM_IDLE, pmrm_pkg::PMRM_PRE: begin
            dv_d = w.data && w.nib == `PMRM_SFD_NIB;
            if (!w.data) begin
              st_d = pmrm_pkg::PMRM_IDLE;
            end else if (!dv_d) begin
              st_d = pmrm_pkg::PMRM_PRE;
            end
            if (w.data && w.nib == `PMRM_BAD_SFD_NIB) begin
              er_d = 1'b1;
            end
          end
          pmrm_pkg::PMRM_FRM: begin
            dv_d = w.data;
          end
          default: begin
            st_d = pmrm_pkg::PMRM_IDLE;
            dv_d = 1'b0;
          end
        endcase
      end
      if (cs2_q[1]) begin
        er_d = w.sym4;
      end
      rxd_d = w.nib;
    end

    // Configuration from the system side and the lock level cross by two flops.
    // Pointers cross only as registered Gray codes, so a sync flop never sees a glitch.
    always_ff @(posedge rx_rclk_i[p] or negedge nrst_i) begin
      if (!nrst_i) begin
        rb_q <= 2'h0;
        wgs1_q <= 2'h0;
        wgs2_q <= 2'h0;
        rgray_q <= 2'h0;
        cs1_q <= 3'h0;
        cs2_q <= 3'h0;
        st_q <= pmrm_pkg::PMRM_IDLE;
        dv_q <= 1'b0;
        er_q <= 1'b0;
        rxd_q <= 4'h0;
      end else begin
        rb_q <= rb_d;
        rgray_q <= gray2(rb_d);
        wgs1_q <= wgray_q;
        wgs2_q <= wgs1_q;
        cs1_q <= {pll_locked_i[p], symbol_mode_i, speed_100_i};
        cs2_q <= cs1_q;
        st_q <= st_d;
        dv_q <= dv_d;
        er_q <= er_d;
        rxd_q <= rxd_d;
      end
    end

    assign rx_dv_o[p] = dv_q;
    assign rx_er_o[p] = er_q;
    assign rxd_o[p] = rxd_q;

    property p_dv100;
      @(posedge rx_rclk_i[p]) disable iff (!nrst_i)
      cs2_q[0] |=> rx_dv_o[p] == $past(w.data);
    endproperty
    a_dv100: assert property (p_dv100) else $error("Valid not data.");

    property p_sfd;
      @(posedge rx_rclk_i[p]) disable iff (!nrst_i)
      !cs2_q[0] && in_pre && w.data && w.nib == `PMRM_SFD_NIB
        ##1 w.data [*2] |-> rx_dv_o[p] [*2];
    endproperty
    a_sfd: assert property (p_sfd) else $error("Valid not held.");

    property p_lock;
      @(posedge rx_rclk_i[p]) disable iff (!nrst_i)
      !cs2_q[2] && !cs2_q[1] |=> rx_er_o[p];
    endproperty
    a_lock: assert property (p_lock) else $error("Unlock not flagged.");

    property p_bad;
      @(posedge rx_rclk_i[p]) disable iff (!nrst_i)
      !cs2_q[0] && !cs2_q[1] && in_pre && w.data && w.nib == `PMRM_BAD_SFD_NIB
        |=> rx_er_o[p] && !rx_dv_o[p];
    endproperty
    a_bad: assert property (p_bad) else $error("Bad delimiter missed.");

    property p_sym;
      @(posedge rx_rclk_i[p]) disable iff (!nrst_i)
      cs2_q[1] && !emp |=> rx_er_o[p] == $past(mem_q[rb_q[0]].sym4);
    endproperty
    a_sym: assert property (p_sym) else $error("Fifth bit wrong.");

    property p_nib;
      @(posedge rx_rclk_i[p]) disable iff (!nrst_i)
      !emp |=> rxd_o[p] == $past(mem_q[rb_q[0]].nib) && rb_q != $past(rb_q);
    endproperty
    a_nib: assert property (p_nib) else $error("Nibble not passed.");
  end

endmodule : pmrm_top
`default_nettype wire

// File: verif/pmrm_mac_model.sv
// Far-side MAC receiver and station management model.
`default_nettype none
module pmrm_mac_model (
  input wire logic [5:0] rx_clk_i,
  input wire logic [5:0] rx_dv_i,
  input wire logic [5:0] rx_er_i,
  input wire logic [5:0][3:0] rxd_i,
  input wire logic mdio_o_i,
  input wire logic mdio_oe_i,
  input wire logic go_i,
  output logic mdc_o,
  output logic mdio_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] nib_q [6];
  logic dv_q [6];
  logic er_q [6];
  int hits [6] = '{default: 0};
  // The line has a pull-up, so a released line reads high.
  assign mdio_o = mdio_oe_i ? mdio_o_i : 1'b1;
  // A 4 MHz clock that stands still between transfers.
  initial begin
    mdc_o = 1'b0;
    forever #125 mdc_o = go_i ? ~mdc_o : 1'b0;
  end
  for (genvar g = 0; g < 6; g++) begin : g_port
    always @(posedge rx_clk_i[g]) begin
      if (rx_dv_i[g] || rx_er_i[g]) begin
        nib_q[g] <= rxd_i[g];
        dv_q[g] <= rx_dv_i[g];
        er_q[g] <= rx_er_i[g];
        hits[g] <= hits[g] + 1;
      end
    end
  end
endmodule : pmrm_mac_model
`default_nettype wire

// File: verif/pmrm_top_bench.sv
// Self-checking bench for the receive MII and management pin block.
`default_nettype none
module pmrm_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 0;
  logic rclk = 0;
  logic nrst_i = 0;
  logic speed_100_i = 1;
  logic symbol_mode_i = 0;
  logic go = 0;
  logic [5:0] pll_locked_i = '1;
  logic [5:0] rx_valid_i = '0;
  pmrm_pkg::pmrm_rxw_type [5:0] rx_word_i = '0;
  logic mdio_drive_i = 0;
  logic mdio_bit_i = 0;
  logic int_enable_i = 0;
  logic status_change_i = 0;
  logic reg19_read_i = 0;
  logic [5:0] rx_ready_o, rx_clk_o, rx_dv_o, rx_er_o;
  logic [5:0][3:0] rxd_o;
  logic mdc, mdio, mdio_o, mdio_oe_o, mdc_sync_o, mdio_sync_o, irq_n, irq_oe;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int got;
  logic seen_mdc;
  pmrm_top DUT (.clk_sys_i, .nrst_i, .speed_100_i, .symbol_mode_i, .pll_locked_i,
    .rx_rclk_i({6{rclk}}), .rx_word_i, .rx_valid_i, .rx_ready_o, .rx_clk_o, .rx_dv_o,
    .rx_er_o, .rxd_o, .mdc_i(mdc), .mdio_i(mdio), .mdio_o, .mdio_oe_o, .mdc_sync_o,
    .mdio_sync_o, .mdio_drive_i, .mdio_bit_i, .int_enable_i, .status_change_i,
    .reg19_read_i, .mgmt_status_irq_n_o(irq_n), .mgmt_status_irq_n_oe_o(irq_oe));
  pmrm_mac_model MAC (.rx_clk_i(rx_clk_o), .rx_dv_i(rx_dv_o), .rx_er_i(rx_er_o),
    .rxd_i(rxd_o), .mdio_o_i(mdio_o), .mdio_oe_i(mdio_oe_o), .go_i(go), .mdc_o(mdc),
    .mdio_o(mdio));
  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #7;
    forever #40 rclk = ~rclk;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic close_out();
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(string nm, logic [5:0] seen, logic [5:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : tick
  // One word at a time keeps the buffer empty, so ready is high when valid rises.
  task automatic send(int p, logic [3:0] n, logic d, logic b, logic s);
    int h;
    h = MAC.hits[p];
    @(posedge clk_sys_i);
    rx_word_i[p] <= '{nib: n, sym4: s, data: d, bad: b};
    rx_valid_i[p] <= 1'b1;
    tick(1);
    rx_valid_i[p] <= 1'b0;
    repeat (40) if (MAC.hits[p] == h) @(posedge clk_sys_i);
    tick(8);
    got = MAC.hits[p] - h;
  endtask : send
  task automatic word(string nm, int p, logic [5:0] exp);
    @(negedge clk_sys_i);
    chk(nm, {MAC.dv_q[p], MAC.er_q[p], MAC.nib_q[p]}, exp);
  endtask : word
  //////////////////////////////////////////////////////////////////////////////
  task automatic rx_tests();
    for (int p = 0; p < 6; p++) begin
      send(p, 4'(p + 9), 1'b1, 1'b0, 1'b0);
      word("data", p, {2'b10, 4'(p + 9)});
      send(p, 4'h3, 1'b1, 1'b1, 1'b0);
      word("code", p, 6'h33);
    end
    tick(1);
    pll_locked_i[2] <= 1'b0;
    tick(20);
    word("lock", 2, 6'h10);
    tick(1);
    pll_locked_i[2] <= 1'b1;
    speed_100_i <= 1'b0;
    tick(10);
    send(1, 4'h5, 1'b1, 1'b0, 1'b0);
    chk("pre", 6'(got), 6'h0);
    send(1, 4'hD, 1'b1, 1'b0, 1'b0);
    word("sfd", 1, 6'h2D);
    send(4, 4'h5, 1'b1, 1'b0, 1'b0);
    send(4, 4'h2, 1'b1, 1'b0, 1'b0);
    @(negedge clk_sys_i);
    chk("badsfd", {MAC.dv_q[4], MAC.er_q[4]}, 2'b01);
    tick(1);
    speed_100_i <= 1'b1;
    symbol_mode_i <= 1'b1;
    tick(10);
    send(0, 4'h6, 1'b1, 1'b0, 1'b1);
    word("sym", 0, 6'h36);
    send(0, 4'h6, 1'b1, 1'b1, 1'b0);
    word("sym0", 0, 6'h26);
  endtask : rx_tests
  task automatic mgmt_tests();
    tick(1);
    status_change_i <= 1'b1;
    tick(1);
    status_change_i <= 1'b0;
    tick(2);
    @(negedge clk_sys_i);
    chk("mask", irq_oe, 1'b0);
    tick(1);
    int_enable_i <= 1'b1;
    tick(2);
    @(negedge clk_sys_i);
    chk("irq", {irq_oe, irq_n}, 2'b10);
    tick(1);
    reg19_read_i <= 1'b1;
    tick(1);
    reg19_read_i <= 1'b0;
    tick(2);
    @(negedge clk_sys_i);
    chk("clr", irq_oe, 1'b0);
    tick(1);
    status_change_i <= 1'b1;
    reg19_read_i <= 1'b1;
    tick(1);
    status_change_i <= 1'b0;
    reg19_read_i <= 1'b0;
    tick(2);
    @(negedge clk_sys_i);
    chk("setwin", irq_oe, 1'b1);
    tick(1);
    go <= 1'b1;
    mdio_drive_i <= 1'b1;
    tick(5);
    @(negedge clk_sys_i);
    chk("mdio", {mdio_oe_o, mdio_o, mdio, mdio_sync_o}, 4'h8);
    tick(1);
    mdio_bit_i <= 1'b1;
    tick(5);
    @(negedge clk_sys_i);
    chk("mdio1", {mdio_oe_o, mdio_o, mdio, mdio_sync_o}, 4'hF);
    seen_mdc = 1'b0;
    repeat (12) begin
      @(negedge clk_sys_i);
      seen_mdc = seen_mdc | mdc_sync_o;
    end
    chk("mdc", seen_mdc, 1'b1);
    tick(1);
    mdio_bit_i <= 1'b0;
    mdio_drive_i <= 1'b0;
    go <= 1'b0;
    tick(5);
    @(negedge clk_sys_i);
    chk("rel", {mdio_oe_o, mdio_o, mdio_sync_o, mdc_sync_o}, 4'b0010);
  endtask : mgmt_tests
  initial begin
    tick(8);
    nrst_i <= 1'b1;
    rx_tests();
    mgmt_tests();
    close_out();
  end
endmodule : pmrm_top_bench
`default_nettype wire
